// [fhx_pkg.sv]
// Shared constants and types of the fieldbus exchange handshake block
package fhx_pkg;

  // Exchange area geometry
  localparam int         AREA_TOTAL = 152;
  localparam logic [8:0] AREA_SUM_MAX = 9'h098;
  localparam logic [7:0] AREA_MIN = 8'h04;
  localparam logic [7:0] HDR_BYTES = 8'h03;
  localparam logic [7:0] TAIL_BACK = 8'h01;
  localparam int         IDX_CTRL = 0;
  localparam int         IDX_SEL = 1;
  localparam int         IDX_LEN = 2;
  localparam int         IDX_DATA = 3;

  // Control byte fields
  localparam int         CB_POSTED = 0;
  localparam int         CB_CONSUMED = 1;
  localparam int         CB_RESYNC = 2;
  localparam int         CB_MORE = 3;
  localparam logic [7:0] CB_PROTO_VAL = 8'h40;
  localparam logic [7:0] CB_PROTO_MASK = 8'hf0;

  // Reserved service selectors
  localparam logic [7:0] SEL_RSVD_A = 8'h02;
  localparam logic [7:0] SEL_RSVD_B = 8'hff;

  // Refresh period
  localparam int REFRESH_MS = 30;
  localparam int CLK_KHZ = 100000;
  localparam int REFRESH_CYCLES = REFRESH_MS * CLK_KHZ;

  // Register map (byte addresses)
  localparam int          ADDR_W = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_TXINFO = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] TXDATA_BASE = 12'h400;
  localparam logic [11:0] RXDATA_BASE = 12'h800;
  localparam logic [11:0] WINDOW_SPAN = 12'h400;
  localparam int          WORD_SHIFT = 2;

  // Control register bits
  localparam int CTL_POST = 0;
  localparam int CTL_RELEASE = 1;
  localparam int CTL_CLRERR = 2;

  // Transmit info register fields
  localparam int INFO_SEL_LSB = 0;
  localparam int INFO_LEN_LSB = 8;
  localparam int INFO_MORE = 16;

  // Status register fields
  localparam int ST_TXFREE = 0;
  localparam int ST_RXAVAIL = 1;
  localparam int ST_RESYNC = 2;
  localparam int ST_CFGERR = 3;
  localparam int ST_POSTERR = 4;
  localparam int ST_RXMORE = 5;
  localparam int ST_LEN_LSB = 8;
  localparam int ST_SEL_LSB = 16;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b01,
    RS_ACK  = 2'b10
  } fhx_resync_type;

endpackage

// [fhx_refresh_timer.sv]
// Free running refresh tick generator
module fhx_refresh_timer #(
  parameter int PERIOD = fhx_pkg::REFRESH_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  output logic      tick
);

  logic [31:0] countReg;
  logic [31:0] countNext;
  logic        tickNext;

  always_comb begin
    tickNext  = 1'b0;
    countNext = countReg + 32'h1;
    if (countReg == 32'(PERIOD - 1)) begin
      countNext = 32'h0;
      tickNext  = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      countReg <= 32'h0;
      tick     <= 1'b0;
    end else begin
      countReg <= countNext;
      tick     <= tickNext;
    end
  end

endmodule

// [fhx_axil_port.sv]
// AXI4-Lite slave handshake front end
module fhx_axil_port (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wrEn,
  output logic [11:0]      wrAddr,
  output logic [31:0]      wrData,
  output logic [3:0]       wrStrb,
  input  wire logic        wrErr,
  input  wire logic [31:0] rdData,
  input  wire logic        rdErr
);

  logic        awHeldReg, awHeldNext, wHeldReg, wHeldNext;
  logic [11:0] addrNext;
  logic [31:0] dataNext, rDataNext;
  logic [3:0]  strbNext;
  logic [1:0]  bRespNext, rRespNext;
  logic        bValidNext, rValidNext, awRdyNext, wRdyNext, arRdyNext;

  assign wrEn = awHeldReg && wHeldReg && !s_axi_bvalid;

  always_comb begin
    awHeldNext = awHeldReg;
    wHeldNext  = wHeldReg;
    addrNext   = wrAddr;
    dataNext   = wrData;
    strbNext   = wrStrb;
    bValidNext = s_axi_bvalid;
    bRespNext  = s_axi_bresp;
    rValidNext = s_axi_rvalid;
    rDataNext  = s_axi_rdata;
    rRespNext  = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeldNext = 1'b1;
      addrNext   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeldNext = 1'b1;
      dataNext  = s_axi_wdata;
      strbNext  = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bValidNext = 1'b0;
    end
    if (wrEn) begin
      awHeldNext = 1'b0;
      wHeldNext  = 1'b0;
      bValidNext = 1'b1;
      bRespNext  = wrErr ? fhx_pkg::RESP_SLVERR : fhx_pkg::RESP_OKAY;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rValidNext = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rValidNext = 1'b1;
      rDataNext  = rdData;
      rRespNext  = rdErr ? fhx_pkg::RESP_SLVERR : fhx_pkg::RESP_OKAY;
    end
    awRdyNext = !awHeldNext && !bValidNext;
    wRdyNext  = !wHeldNext && !bValidNext;
    arRdyNext = !rValidNext;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      awHeldReg     <= 1'b0;
      wHeldReg      <= 1'b0;
      wrAddr        <= 12'h000;
      wrData        <= 32'h0;
      wrStrb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      awHeldReg     <= awHeldNext;
      wHeldReg      <= wHeldNext;
      wrAddr        <= addrNext;
      wrData        <= dataNext;
      wrStrb        <= strbNext;
      s_axi_bvalid  <= bValidNext;
      s_axi_bresp   <= bRespNext;
      s_axi_rvalid  <= rValidNext;
      s_axi_rdata   <= rDataNext;
      s_axi_rresp   <= rRespNext;
      s_axi_awready <= awRdyNext;
      s_axi_wready  <= wRdyNext;
      s_axi_arready <= arRdyNext;
    end
  end

endmodule

// [fhx_exchange.sv]
// Slave side cyclic exchange area message layer with AXI4-Lite access
//
// Added by the designer: register access over AXI4-Lite and the address map.
module fhx_exchange #(
  parameter int REFRESH_PERIOD = fhx_pkg::REFRESH_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  fbInSize,
  input  wire logic [7:0]  fbOutSize,
  input  wire logic        fbOutWe,
  input  wire logic [7:0]  fbOutAddr,
  input  wire logic [7:0]  fbOutData,
  input  wire logic [7:0]  fbInAddr,
  output logic [7:0]       fbInData,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam int N = fhx_pkg::AREA_TOTAL;

  logic [7:0] inArea [N];
  logic [7:0] inAreaNext [N];
  logic [7:0] outArea [N];
  logic [7:0] outAreaNext [N];
  logic [7:0] txBuf [N];
  logic [7:0] txBufNext [N];
  logic [7:0] rxBuf [N];
  logic [7:0] rxBufNext [N];

  logic [7:0] inSizeReg, inSizeNext, outSizeReg, outSizeNext;
  logic [7:0] mstCtrlReg, mstCtrlNext, txSelReg, txSelNext, txLenReg, txLenNext;
  logic       cfgErrReg, cfgErrNext, txMoreReg, txMoreNext;
  logic       txPendReg, txPendNext, rxAvailReg, rxAvailNext;
  logic       relPendReg, relPendNext, postErrReg, postErrNext;
  logic [7:0] fbInDataNext, sampledCtrl, ctrl, wrIdx, rdIdx;
  logic       tick, wrEn, wrErr, rdErr, postOk;
  logic [11:0] wrAddr;
  logic [31:0] wrData, rdData;
  logic [3:0]  wrStrb;
  fhx_pkg::fhx_resync_type rsState, rsNext;

  // Byte index inside a word-per-byte window, or all ones when outside it
  function automatic logic [7:0] winIdx(input logic [11:0] addr, input logic [11:0] base);
    logic [11:0] off;
    off = addr - base;
    if (addr >= base && off < fhx_pkg::WINDOW_SPAN && (off >> fhx_pkg::WORD_SHIFT) < 12'(N))
      winIdx = off[9:2];
    else
      winIdx = 8'hff;
  endfunction

  function automatic logic [7:0] lenLimit(input logic [7:0] size);
    lenLimit = size - fhx_pkg::HDR_BYTES;
  endfunction

  function automatic logic sizeBad(input logic [7:0] a, input logic [7:0] b);
    sizeBad = ({1'b0, a} + {1'b0, b} > fhx_pkg::AREA_SUM_MAX) ||
              (a < fhx_pkg::AREA_MIN) || (b < fhx_pkg::AREA_MIN);
  endfunction

  fhx_refresh_timer #(.PERIOD(REFRESH_PERIOD)) u_timer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tick     (tick)
  );

  fhx_axil_port u_port (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrEn          (wrEn),
    .wrAddr        (wrAddr),
    .wrData        (wrData),
    .wrStrb        (wrStrb),
    .wrErr         (wrErr),
    .rdData        (rdData),
    .rdErr         (rdErr)
  );

  // Master control byte counts only when its trailing copy agrees
  assign sampledCtrl = (outArea[fhx_pkg::IDX_CTRL] == outArea[outSizeReg - fhx_pkg::TAIL_BACK])
                       ? outArea[fhx_pkg::IDX_CTRL] : mstCtrlReg;
  assign ctrl = inArea[fhx_pkg::IDX_CTRL];
  assign postOk = !cfgErrReg && !txPendReg && txLenReg <= lenLimit(inSizeReg)
                  && txSelReg != fhx_pkg::SEL_RSVD_A && txSelReg != fhx_pkg::SEL_RSVD_B
                  && (!txMoreReg || txLenReg == lenLimit(inSizeReg));
  assign wrIdx = winIdx(wrAddr, fhx_pkg::TXDATA_BASE);
  assign rdIdx = winIdx(s_axi_araddr, fhx_pkg::RXDATA_BASE);
  assign wrErr = !(wrAddr == fhx_pkg::REG_CTRL || wrAddr == fhx_pkg::REG_TXINFO
                   || wrIdx != 8'hff);

  always_comb begin
    rdData = 32'h0;
    rdErr  = 1'b0;
    if (s_axi_araddr == fhx_pkg::REG_STATUS) begin
      rdData[fhx_pkg::ST_TXFREE]  = !txPendReg;
      rdData[fhx_pkg::ST_RXAVAIL] = rxAvailReg;
      rdData[fhx_pkg::ST_RESYNC]  = rsState == fhx_pkg::RS_ACK;
      rdData[fhx_pkg::ST_CFGERR]  = cfgErrReg;
      rdData[fhx_pkg::ST_POSTERR] = postErrReg;
      rdData[fhx_pkg::ST_RXMORE]  = rxBuf[fhx_pkg::IDX_CTRL][fhx_pkg::CB_MORE];
      rdData[fhx_pkg::ST_LEN_LSB +: 8] = rxBuf[fhx_pkg::IDX_LEN];
      rdData[fhx_pkg::ST_SEL_LSB +: 8] = rxBuf[fhx_pkg::IDX_SEL];
    end else if (s_axi_araddr == fhx_pkg::REG_TXINFO) begin
      rdData[fhx_pkg::INFO_SEL_LSB +: 8] = txSelReg;
      rdData[fhx_pkg::INFO_LEN_LSB +: 8] = txLenReg;
      rdData[fhx_pkg::INFO_MORE]         = txMoreReg;
    end else if (rdIdx != 8'hff) begin
      rdData[7:0] = rxBuf[rdIdx];
    end else if (s_axi_araddr != fhx_pkg::REG_CTRL) begin
      rdErr = 1'b1;
    end
  end

  always_comb begin
    logic [7:0] c;
    c = ctrl;
    inAreaNext  = inArea;
    outAreaNext = outArea;
    txBufNext   = txBuf;
    rxBufNext   = rxBuf;
    inSizeNext  = inSizeReg;
    outSizeNext = outSizeReg;
    cfgErrNext  = cfgErrReg;
    mstCtrlNext = mstCtrlReg;
    txSelNext   = txSelReg;
    txLenNext   = txLenReg;
    txMoreNext  = txMoreReg;
    txPendNext  = txPendReg;
    rxAvailNext = rxAvailReg;
    relPendNext = relPendReg;
    postErrNext = postErrReg;
    rsNext      = rsState;
    // Only the master side writes the output area
    if (fbOutWe && fbOutAddr < outSizeReg) begin
      outAreaNext[fbOutAddr] = fbOutData;
    end
    fbInDataNext = (fbInAddr < inSizeReg) ? inArea[fbInAddr] : 8'h00;
    if (tick) begin
      inSizeNext  = fbInSize;
      outSizeNext = fbOutSize;
      cfgErrNext  = sizeBad(fbInSize, fbOutSize);
      if (!cfgErrReg) begin
        mstCtrlNext = sampledCtrl;
        unique case (rsState)
          fhx_pkg::RS_IDLE: begin
            if (sampledCtrl[fhx_pkg::CB_RESYNC]) begin
              c[fhx_pkg::CB_POSTED]   = 1'b0;
              c[fhx_pkg::CB_CONSUMED] = 1'b0;
              c[fhx_pkg::CB_MORE]     = 1'b0;
              c[fhx_pkg::CB_RESYNC]   = 1'b1;
              txPendNext  = 1'b0;
              rxAvailNext = 1'b0;
              relPendNext = 1'b0;
              rsNext      = fhx_pkg::RS_ACK;
            end else begin
              if (relPendReg) begin
                c[fhx_pkg::CB_CONSUMED] = !c[fhx_pkg::CB_CONSUMED];
                rxAvailNext = 1'b0;
                relPendNext = 1'b0;
              end else if (!rxAvailReg
                           && sampledCtrl[fhx_pkg::CB_CONSUMED] != c[fhx_pkg::CB_CONSUMED]) begin
                rxBufNext   = outArea;
                rxAvailNext = 1'b1;
              end
              if (txPendReg && c[fhx_pkg::CB_POSTED] == sampledCtrl[fhx_pkg::CB_POSTED]) begin
                for (int i = fhx_pkg::IDX_DATA; i < N; i++) begin
                  if (8'(i) < inSizeReg - fhx_pkg::TAIL_BACK) begin
                    inAreaNext[i] = txBuf[i - fhx_pkg::IDX_DATA];
                  end
                end
                inAreaNext[fhx_pkg::IDX_SEL] = txSelReg;
                inAreaNext[fhx_pkg::IDX_LEN] = txLenReg;
                c[fhx_pkg::CB_POSTED] = !c[fhx_pkg::CB_POSTED];
                c[fhx_pkg::CB_MORE]   = txMoreReg;
                txPendNext = 1'b0;
              end
            end
          end
          fhx_pkg::RS_ACK: begin
            if (!sampledCtrl[fhx_pkg::CB_RESYNC]) begin
              c[fhx_pkg::CB_RESYNC] = 1'b0;
              rsNext = fhx_pkg::RS_IDLE;
            end
          end
        endcase
        c = (c & ~fhx_pkg::CB_PROTO_MASK) | fhx_pkg::CB_PROTO_VAL;
        inAreaNext[fhx_pkg::IDX_CTRL] = c;
        inAreaNext[inSizeReg - fhx_pkg::TAIL_BACK] = c;
      end
    end
    if (wrEn && !wrErr) begin
      if (wrAddr == fhx_pkg::REG_CTRL) begin
        if (wrData[fhx_pkg::CTL_CLRERR]) begin
          postErrNext = 1'b0;
        end
        if (wrData[fhx_pkg::CTL_POST] && wrStrb[0]) begin
          if (postOk) begin
            txPendNext = 1'b1;
          end else begin
            postErrNext = 1'b1;
          end
        end
        if (wrData[fhx_pkg::CTL_RELEASE] && wrStrb[0] && rxAvailNext) begin
          relPendNext = 1'b1;
        end
      end else if (wrAddr == fhx_pkg::REG_TXINFO && !txPendReg) begin
        if (wrStrb[0]) begin
          txSelNext = wrData[fhx_pkg::INFO_SEL_LSB +: 8];
        end
        if (wrStrb[1]) begin
          txLenNext = wrData[fhx_pkg::INFO_LEN_LSB +: 8];
        end
        if (wrStrb[2]) begin
          txMoreNext = wrData[fhx_pkg::INFO_MORE];
        end
      end else if (wrIdx != 8'hff && !txPendReg && wrStrb[0]) begin
        txBufNext[wrIdx] = wrData[7:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < N; i++) begin
        inArea[i]  <= 8'h00;
        outArea[i] <= 8'h00;
        txBuf[i]   <= 8'h00;
        rxBuf[i]   <= 8'h00;
      end
      inSizeReg  <= fhx_pkg::AREA_MIN;
      outSizeReg <= fhx_pkg::AREA_MIN;
      cfgErrReg  <= 1'b1;
      mstCtrlReg <= 8'h00;
      txSelReg   <= 8'h00;
      txLenReg   <= 8'h00;
      txMoreReg  <= 1'b0;
      txPendReg  <= 1'b0;
      rxAvailReg <= 1'b0;
      relPendReg <= 1'b0;
      postErrReg <= 1'b0;
      rsState    <= fhx_pkg::RS_IDLE;
      fbInData   <= 8'h00;
    end else begin
      inArea     <= inAreaNext;
      outArea    <= outAreaNext;
      txBuf      <= txBufNext;
      rxBuf      <= rxBufNext;
      inSizeReg  <= inSizeNext;
      outSizeReg <= outSizeNext;
      cfgErrReg  <= cfgErrNext;
      mstCtrlReg <= mstCtrlNext;
      txSelReg   <= txSelNext;
      txLenReg   <= txLenNext;
      txMoreReg  <= txMoreNext;
      txPendReg  <= txPendNext;
      rxAvailReg <= rxAvailNext;
      relPendReg <= relPendNext;
      postErrReg <= postErrNext;
      rsState    <= rsNext;
      fbInData   <= fbInDataNext;
    end
  end

  sequence seqResyncSeen;
    tick && !cfgErrReg && rsState == fhx_pkg::RS_IDLE && sampledCtrl[fhx_pkg::CB_RESYNC];
  endsequence

  sequence seqAckedClear;
    ctrl[fhx_pkg::CB_RESYNC] && ctrl[fhx_pkg::CB_CONSUMED:fhx_pkg::CB_POSTED] == 2'b00;
  endsequence

  chk_resync_ack: assert property (@(posedge core_clk) disable iff (sys_rst)
    seqResyncSeen |=> seqAckedClear) else $error("resync not acknowledged with cleared toggles");
  chk_proto_pattern: assert property (@(posedge core_clk) disable iff (sys_rst)
    $changed(ctrl) |-> (ctrl & fhx_pkg::CB_PROTO_MASK) == fhx_pkg::CB_PROTO_VAL)
    else $error("input control byte lacks protocol pattern");
  chk_tail_copy: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(tick) && !$past(cfgErrReg) |-> ctrl == inArea[$past(inSizeReg) - fhx_pkg::TAIL_BACK])
    else $error("input consistency copy differs from control byte");
  chk_post_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    $changed(ctrl[fhx_pkg::CB_POSTED]) && !ctrl[fhx_pkg::CB_RESYNC] |->
    $past(tick) && $past(txPendReg) && !txPendReg
    && $past(sampledCtrl[fhx_pkg::CB_POSTED]) == $past(ctrl[fhx_pkg::CB_POSTED]))
    else $error("posted toggle moved without a free slot");
  chk_consume_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    $changed(ctrl[fhx_pkg::CB_CONSUMED]) && !ctrl[fhx_pkg::CB_RESYNC] |->
    $past(tick) && $past(relPendReg) && !rxAvailReg)
    else $error("consumed toggle moved without a release");
  chk_rx_capture: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick && !cfgErrReg && rsState == fhx_pkg::RS_IDLE && !sampledCtrl[fhx_pkg::CB_RESYNC]
    && !rxAvailReg && !relPendReg
    && sampledCtrl[fhx_pkg::CB_CONSUMED] != ctrl[fhx_pkg::CB_CONSUMED]
    |=> rxAvailReg && rxBuf[fhx_pkg::IDX_LEN] == $past(outArea[fhx_pkg::IDX_LEN]))
    else $error("new output block not captured");
  chk_len_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
    $changed(ctrl[fhx_pkg::CB_POSTED]) && !ctrl[fhx_pkg::CB_RESYNC] |->
    inArea[fhx_pkg::IDX_LEN] <= lenLimit(inSizeReg)
    && (!ctrl[fhx_pkg::CB_MORE] || inArea[fhx_pkg::IDX_LEN] == lenLimit(inSizeReg)))
    else $error("posted length outside its limit");
  chk_refresh_gap: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick |=> !tick [*8]) else $error("refresh ticks too close together");
  chk_input_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(tick) |-> $stable(ctrl)) else $error("input control changed between refreshes");

endmodule

// [fhx_fb_master.sv]
// Behavioural fieldbus master that writes the output area and reads the input area
module fhx_fb_master #(
  parameter logic [7:0] LAST = 8'h07
) (
  input  wire logic       core_clk,
  output logic            fbOutWe,
  output logic [7:0]      fbOutAddr,
  output logic [7:0]      fbOutData,
  output logic [7:0]      fbInAddr,
  input  wire logic [7:0] fbInData
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    fbOutWe = 1'b0;
    fbOutAddr = 8'h00;
    fbOutData = 8'h00;
    fbInAddr = 8'h00;
  end
  // Writes only the output area; data line shows the inverse once released
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    fbOutWe <= 1'b1;
    fbOutAddr <= a;
    fbOutData <= d;
    @(posedge core_clk);
    fbOutWe <= 1'b0;
    fbOutData <= ~d;
    @(posedge core_clk);
  endtask
  // Control byte and its trailing copy; toggles, resync hold and pattern come from caller
  task automatic ctrl(input logic [7:0] c);
    put(8'h00, c);
    put(LAST, c);
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    fbInAddr <= a;
    repeat (2) @(posedge core_clk);
    d = fbInData;
  endtask
endmodule

// [fieldbus_exchange_handshake_bench.sv]
// Self-checking bench of the exchange handshake block
module fieldbus_exchange_handshake_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 0, sys_rst = 1, awv = 0, wv = 0, arv = 0, bry = 0, rry = 0;
  logic [7:0]  inSz = 8'h08, outSz = 8'h08;
  logic [3:0]  wstb = 4'hf;
  logic [11:0] aw = 0, ar = 0;
  logic [31:0] wd = 0, rd, rdat;
  logic        awr, wr, bv, arr, rv, we;
  logic [1:0]  br, rr, resp;
  logic [7:0]  oa, od, ia, id, b;
  int          err_total = 0, tests_run = 0;
  initial forever #5 core_clk = ~core_clk;
  fhx_exchange #(.REFRESH_PERIOD(20)) u_fhx_exchange (.core_clk(core_clk), .sys_rst(sys_rst),
    .fbInSize(inSz), .fbOutSize(outSz), .fbOutWe(we), .fbOutAddr(oa), .fbOutData(od),
    .fbInAddr(ia), .fbInData(id), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(wstb), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry));
  fhx_fb_master u_fhx_fb_master (.core_clk(core_clk), .fbOutWe(we), .fbOutAddr(oa),
    .fbOutData(od), .fbInAddr(ia), .fbInData(id));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 60) begin
      err_total++;
      complete_run;
    end
  endtask
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
      n++;
    end while (bv !== 1'b1 && n < 60);
    hang(n);
    resp = br;
    bry <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rreg(input logic [11:0] a);
    int n;
    n = 0;
    ar <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arr === 1'b1) arv <= 1'b0;
      n++;
    end while (rv !== 1'b1 && n < 60);
    hang(n);
    rd = rdat;
    resp = rr;
    rry <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic gchk(input logic [7:0] a, input logic [7:0] e, input string n);
    u_fhx_fb_master.get(a, b);
    chk({24'h0, b}, {24'h0, e}, n);
  endtask
  task automatic settle;
    repeat (50) @(posedge core_clk);
  endtask
  task automatic t_idle;
    settle;
    gchk(8'h00, 8'h40, "in ctrl");
    gchk(8'h07, 8'h40, "in copy");
    rreg(fhx_pkg::REG_STATUS);
    chk(rd, 32'h1, "status");
    rreg(12'h00c);
    chk({30'h0, resp}, {30'h0, fhx_pkg::RESP_SLVERR}, "unmapped");
    wreg(12'h00c, 32'h0);
    chk({30'h0, resp}, {30'h0, fhx_pkg::RESP_SLVERR}, "wr unmapped");
    wstb <= 4'h2;
    wreg(fhx_pkg::REG_TXINFO, 32'h10203);
    chk({30'h0, resp}, {30'h0, fhx_pkg::RESP_OKAY}, "wr okay");
    wstb <= 4'hf;
    rreg(fhx_pkg::REG_TXINFO);
    chk(rd, 32'h200, "strobe");
    $display("test idle done");
  endtask
  task automatic t_badpost;
    logic [31:0] bad [4];
    bad = '{32'h102, 32'h1ff, 32'h600, 32'h10200};
    foreach (bad[i]) begin
      wreg(fhx_pkg::REG_TXINFO, bad[i]);
      wreg(fhx_pkg::REG_CTRL, 32'h1);
      rreg(fhx_pkg::REG_STATUS);
      chk(rd[fhx_pkg::ST_POSTERR], 1, "post error");
      wreg(fhx_pkg::REG_CTRL, 32'h4);
    end
    gchk(8'h00, 8'h40, "no post");
    $display("test badpost done");
  endtask
  task automatic t_post;
    wreg(fhx_pkg::TXDATA_BASE, 32'ha5);
    wreg(fhx_pkg::REG_TXINFO, 32'h100);
    wreg(fhx_pkg::REG_CTRL, 32'h1);
    settle;
    gchk(8'h00, 8'h41, "posted");
    gchk(8'h01, 8'h00, "selector");
    gchk(8'h02, 8'h01, "length");
    gchk(8'h03, 8'ha5, "payload");
    wreg(fhx_pkg::TXDATA_BASE, 32'h5a);
    wreg(fhx_pkg::REG_TXINFO, 32'h10500);
    wreg(fhx_pkg::REG_CTRL, 32'h1);
    settle;
    gchk(8'h00, 8'h41, "held");
    u_fhx_fb_master.ctrl(8'h41);
    settle;
    gchk(8'h00, 8'h48, "fragment");
    gchk(8'h07, 8'h48, "frag copy");
    gchk(8'h02, 8'h05, "frag len");
    gchk(8'h03, 8'h5a, "frag data");
    u_fhx_fb_master.ctrl(8'h40);
    $display("test post done");
  endtask
  task automatic t_recv;
    u_fhx_fb_master.put(8'h01, 8'h07);
    u_fhx_fb_master.put(8'h02, 8'h02);
    u_fhx_fb_master.put(8'h03, 8'h3c);
    u_fhx_fb_master.put(8'h00, 8'h42);
    settle;
    rreg(fhx_pkg::REG_STATUS);
    chk(rd[fhx_pkg::ST_RXAVAIL], 0, "stale copy");
    u_fhx_fb_master.put(8'h07, 8'h42);
    settle;
    rreg(fhx_pkg::REG_STATUS);
    chk(rd, 32'h70203, "rx status");
    rreg(fhx_pkg::RXDATA_BASE + 12'h00c);
    chk(rd, 32'h3c, "rx data");
    wreg(fhx_pkg::REG_CTRL, 32'h2);
    settle;
    gchk(8'h00, 8'h4a, "consumed");
    rreg(fhx_pkg::REG_STATUS);
    chk(rd[fhx_pkg::ST_RXAVAIL], 0, "rx freed");
    $display("test recv done");
  endtask
  task automatic t_resync;
    u_fhx_fb_master.ctrl(8'h44);
    settle;
    gchk(8'h00, 8'h44, "resync ack");
    rreg(fhx_pkg::REG_STATUS);
    chk(rd[fhx_pkg::ST_RESYNC], 1, "resync st");
    settle;
    gchk(8'h07, 8'h44, "ack held");
    u_fhx_fb_master.ctrl(8'h40);
    settle;
    gchk(8'h00, 8'h40, "resync end");
    $display("test resync done");
  endtask
  task automatic t_cfg;
    inSz <= 8'h95;
    settle;
    rreg(fhx_pkg::REG_STATUS);
    chk(rd[fhx_pkg::ST_CFGERR], 1, "size sum");
    u_fhx_fb_master.ctrl(8'h42);
    settle;
    gchk(8'h00, 8'h40, "frozen");
    inSz <= 8'h08;
    settle;
    rreg(fhx_pkg::REG_STATUS);
    chk(rd[fhx_pkg::ST_CFGERR], 0, "size ok");
    $display("test cfg done");
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_idle;
    t_badpost;
    t_post;
    t_recv;
    t_resync;
    t_cfg;
    complete_run;
  end
endmodule
